// ==== tb/amf_ce_ram_model.sv ====
// engine RAM and modulator stream model for the sample path
`timescale 1ns/100ps
module amf_ce_ram_model (
  input wire logic core_clk,
  input wire logic modPositive,
  input wire logic ceRamWrite,
  input wire logic [7:0] ceRamAddr,
  input wire logic [31:0] ceRamData,
  output logic modulatorBit
);
  // ===========================================================
  // storage
  logic [31:0] mem [0:255]; // engine RAM words, cleared at start
  int writeCount; // stores seen
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'h00000000;
    writeCount = 0;
    modulatorBit = 1'b0;
  end
  // full-scale stream: constant level keeps the sum exact
  always @(posedge core_clk)
    modulatorBit <= modPositive;
  // capture each store, only the addressed word changes
  always @(posedge core_clk)
  begin
    if (ceRamWrite === 1'b1)
    begin
      mem[ceRamAddr] <= ceRamData;
      writeCount <= writeCount + 1;
    end
  end
endmodule // amf_ce_ram_model

// ==== tb/amf_sample_path_chk.sv ====
// port checker for the converter sample path
`timescale 1ns/100ps
module amf_sample_path_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic converterClock,
  input wire logic [3:0] slotInputSelect,
  input wire logic conversionStart,
  input wire logic frameSync,
  input wire logic pair01DiffEnable,
  input wire logic preampGain8Enable,
  input wire logic remoteLinkBEnable,
  input wire logic fastClockSelect,
  input wire logic converterDivSelect,
  input wire logic ceRamWrite,
  input wire logic [7:0] ceRamAddr,
  input wire logic [31:0] ceRamData
);
  // ===========================================================
  // one clock domain, one reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // fast converter clock: two core clocks high, then low
  sequence s_fastHigh;
    converterClock ##1 converterClock ##1 !converterClock;
  endsequence
  // ===========================================================
  // properties
  property p_rdIdle;
    !$past(regRd) |-> regRdData == 8'h00;
  endproperty
  property p_diffWr;
    regWr && regAddr == amf_pkg::OFS_INPUT_CFG |=> pair01DiffEnable == $past(regWrData[4]);
  endproperty
  property p_preWr;
    regWr && regAddr == amf_pkg::OFS_PREAMP_CFG |=> preampGain8Enable == $past(regWrData[5]);
  endproperty
  property p_rmtWr;
    regWr && regAddr == amf_pkg::OFS_REMOTE_CFG |=> remoteLinkBEnable == $past(regWrData[4]);
  endproperty
  property p_clkWr;
    regWr && regAddr == amf_pkg::OFS_CLOCK_CFG |=>
      fastClockSelect == $past(regWrData[4]) && converterDivSelect == $past(regWrData[5]);
  endproperty
  // settled divider only, a change may cut a half period short
  property p_convClk;
    $rose(converterClock) && converterDivSelect && $past(converterDivSelect, 4) |-> s_fastHigh;
  endproperty
  property p_startPulse;
    conversionStart |=> !conversionStart;
  endproperty
  property p_frameStart;
    frameSync |-> conversionStart;
  endproperty
  property p_wrPulse;
    ceRamWrite |=> !ceRamWrite;
  endproperty
  property p_wordForm;
    ceRamWrite |-> ceRamData[8:0] == 9'h000 && ceRamAddr[7:4] == 4'h0;
  endproperty
  property p_selHold;
    conversionStart |=> $stable(slotInputSelect) [*8];
  endproperty
  // ===========================================================
  // assertions
  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero when idle");
  a_diffWr: assert property (p_diffWr) else $error("differential enable wrong");
  a_preWr: assert property (p_preWr) else $error("preamp enable wrong");
  a_rmtWr: assert property (p_rmtWr) else $error("remote enable wrong");
  a_clkWr: assert property (p_clkWr) else $error("clock selects wrong");
  a_convClk: assert property (p_convClk) else $error("converter clock period wrong");
  a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
  a_frameStart: assert property (p_frameStart) else $error("frame sync off a start");
  a_wrPulse: assert property (p_wrPulse) else $error("write pulse too long");
  a_wordForm: assert property (p_wordForm) else $error("stored word form wrong");
  a_selHold: assert property (p_selHold) else $error("select moved in conversion");
endmodule // amf_sample_path_chk

bind amf_sample_path amf_sample_path_chk u_amf_sample_path_chk (
  .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .converterClock(converterClock),
  .slotInputSelect(slotInputSelect), .conversionStart(conversionStart), .frameSync(frameSync),
  .pair01DiffEnable(pair01DiffEnable), .preampGain8Enable(preampGain8Enable),
  .remoteLinkBEnable(remoteLinkBEnable), .fastClockSelect(fastClockSelect),
  .converterDivSelect(converterDivSelect), .ceRamWrite(ceRamWrite), .ceRamAddr(ceRamAddr),
  .ceRamData(ceRamData)
);

// ==== tb/amf_sample_path_tb.sv ====
// self-checking bench for the converter sample path
`timescale 1ns/100ps
module amf_sample_path_tb;
  // ===========================================================
  // stimulus and observation signals
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic modPositive = 1'b1;
  logic [7:0] regRdData;
  logic modulatorBit, converterClock, conversionStart, frameSync, ceRamWrite;
  logic pair01DiffEnable, pair45DiffEnable, pair67DiffEnable, preampGain8Enable;
  logic remoteLinkBEnable, remoteLinkCEnable, fastClockSelect, converterDivSelect;
  logic [3:0] slotInputSelect;
  logic [7:0] ceRamAddr;
  logic [31:0] ceRamData;
  int failCount = 0;
  int checks = 0;
  always #20 core_clk = ~core_clk;
  amf_sample_path u_amf_sample_path (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .modulatorBit(modulatorBit), .converterClock(converterClock), .slotInputSelect(slotInputSelect),
    .conversionStart(conversionStart), .frameSync(frameSync), .pair01DiffEnable(pair01DiffEnable),
    .pair45DiffEnable(pair45DiffEnable), .pair67DiffEnable(pair67DiffEnable),
    .preampGain8Enable(preampGain8Enable), .remoteLinkBEnable(remoteLinkBEnable),
    .remoteLinkCEnable(remoteLinkCEnable), .fastClockSelect(fastClockSelect),
    .converterDivSelect(converterDivSelect), .ceRamWrite(ceRamWrite), .ceRamAddr(ceRamAddr),
    .ceRamData(ceRamData));
  amf_ce_ram_model u_amf_ce_ram_model (.core_clk(core_clk), .modPositive(modPositive),
    .ceRamWrite(ceRamWrite), .ceRamAddr(ceRamAddr), .ceRamData(ceRamData),
    .modulatorBit(modulatorBit));
  // ===========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic regRead(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk(32'(regRdData), 32'(exp));
  endtask
  // bounded wait for the next slot start, then its select
  task automatic waitStart(input logic [3:0] sel, input logic fs);
    for (int n = 0; n < 5000 && conversionStart !== 1'b1; n++)
      @(posedge core_clk) #1;
    chk(32'(conversionStart), 32'h1);
    chk(32'(slotInputSelect), 32'(sel));
    chk(32'(frameSync), 32'(fs));
    @(posedge core_clk) #1;
  endtask
  // bounded wait for the next store; the first after a mode change is mixed
  task automatic waitWrite(input logic [7:0] a, input logic [31:0] d, input bit judge);
    for (int n = 0; n < 5000 && ceRamWrite !== 1'b1; n++)
      @(posedge core_clk) #1;
    chk(32'(ceRamWrite), 32'h1);
    if (judge)
    begin
      chk(32'(ceRamAddr), 32'(a));
      chk(ceRamData, d);
    end
    @(posedge core_clk) #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ===========================================================
  // scenarios
  task automatic t_reset;
    logic [15:0] ofs [7] = '{16'h210c, 16'h2200, 16'h2704, 16'h2709, 16'h2100, 16'h2105, 16'h2300};
    foreach (ofs[i])
      regRead(ofs[i], amf_pkg::CFG_RESET);
    chk(32'(ceRamWrite), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs;
    regWrite(amf_pkg::OFS_INPUT_CFG, 8'hd0);
    regWrite(amf_pkg::OFS_PREAMP_CFG, 8'h20);
    regWrite(amf_pkg::OFS_REMOTE_CFG, 8'h30);
    // with remote links on, voltage handles 7, 8, 9 sit in slots 3, 4, 5
    regWrite(16'h2104, 8'h70);
    regWrite(16'h2103, 8'h98);
    regWrite(amf_pkg::OFS_CLOCK_CFG, 8'h30);
    regWrite(16'h2300, 8'hff);
    chk(32'({pair01DiffEnable, pair45DiffEnable, pair67DiffEnable}), 32'h7);
    chk(32'({preampGain8Enable, remoteLinkBEnable, remoteLinkCEnable}), 32'h7);
    chk(32'({fastClockSelect, converterDivSelect}), 32'h3);
    regRead(amf_pkg::OFS_INPUT_CFG, 8'hd0);
    regRead(16'h2300, 8'h00);
    regRead(16'h2104, 8'h70);
    regRead(16'h2103, 8'h98);
    regWrite(amf_pkg::OFS_REMOTE_CFG, 8'h00);
    regWrite(amf_pkg::OFS_CLOCK_CFG, 8'h20);
    chk(32'({remoteLinkBEnable, remoteLinkCEnable, fastClockSelect}), 32'h0);
    $display("test registers done");
  endtask
  task automatic t_conv21;
    logic [31:0] expW;
    expW = 32'(amf_pkg::FILT_CYC_21) << amf_pkg::RES_SHIFT;
    regWrite(amf_pkg::OFS_INPUT_CFG, 8'h02);
    regWrite(amf_pkg::OFS_SLOT_LAST, 8'h35); // current handle 5 then its voltage 3
    regWrite(amf_pkg::OFS_SLOT_FIRST, 8'h20);
    waitStart(4'h5, 1'b1);
    waitWrite(8'h05, expW, 1'b1);
    waitStart(4'h3, 1'b0);
    waitWrite(8'h03, expW, 1'b1);
    waitStart(4'h5, 1'b1);
    chk(u_amf_ce_ram_model.mem[5], expW);
    chk(u_amf_ce_ram_model.mem[4], 32'h0);
    chk(32'(u_amf_ce_ram_model.writeCount), 32'h2);
    $display("test conversion 21 done");
  endtask
  task automatic t_conv22;
    logic [31:0] expW;
    expW = -(32'(amf_pkg::FILT_CYC_22) << amf_pkg::RES_SHIFT);
    modPositive <= 1'b0;
    regWrite(amf_pkg::OFS_INPUT_CFG, 8'h04);
    waitWrite(8'h05, 32'h0, 1'b0);
    waitWrite(8'h03, expW, 1'b1);
    chk(u_amf_ce_ram_model.mem[3], expW);
    $display("test conversion 22 done");
  endtask
  // ===========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_conv21();
    t_conv22();
    wrap_up();
  end
  // about nine and a half thousand cycles expected, generous margin
  initial
  begin
    repeat (40000) @(posedge core_clk);
    failCount++;
    wrap_up();
  end
endmodule // amf_sample_path_tb

// ==== verilog/amf_pkg.sv ====
// constants shared by the converter sample-path design
package amf_pkg;

  // ===========================================================
  // register byte offsets
  localparam logic [15:0] OFS_SLOT_FIRST = 16'h2100; // frame count + slot 10 select
  localparam logic [15:0] OFS_SLOT_LAST = 16'h2105; // slot 0 and slot 1 selects
  localparam logic [15:0] OFS_INPUT_CFG = 16'h210c; // filter length + differential enables
  localparam logic [15:0] OFS_CLOCK_CFG = 16'h2200; // clock speed selects
  localparam logic [15:0] OFS_PREAMP_CFG = 16'h2704; // pre-amplifier enable
  localparam logic [15:0] OFS_REMOTE_CFG = 16'h2709; // remote sensor enables

  // ===========================================================
  // field positions
  localparam int FLD_FILT_LSB = 1; // filter_length_code[1:0] at [2:1]
  localparam int FLD_DIFF01 = 4; // pair01_differential_enable
  localparam int FLD_DIFF45 = 6; // pair45_differential_enable
  localparam int FLD_DIFF67 = 7; // pair67_differential_enable
  localparam int FLD_FAST_CLK = 4; // fast master clock select
  localparam int FLD_CONV_DIV = 5; // converter clock divider select
  localparam int FLD_PREAMP = 5; // gain-of-8 pre-amplifier enable
  localparam int FLD_RMT_B = 4; // remote_link_b_enable
  localparam int FLD_RMT_C = 5; // remote_link_c_enable
  localparam int FLD_FRAME_LSB = 4; // frame_slot_count[3:0] at [7:4]

  // ===========================================================
  // reset values and limits
  localparam logic [7:0] CFG_RESET = 8'h00; // every config byte clears
  localparam logic [3:0] MAX_SLOTS = 4'hb; // longest frame, eleven slots
  localparam logic [1:0] FILT_CODE_22 = 2'h2; // code 10 -> 22-bit result

  // ===========================================================
  // result formatting
  localparam int RES_SHIFT = 9; // left-justify distance
  localparam int RES_BITS_21 = 21; // resolution incl. sign, code 01
  localparam int RES_BITS_22 = 22; // resolution incl. sign, code 10

  // ===========================================================
  // timing counts in core clocks / converter cycles
  localparam logic [3:0] CONV_HALF_SLOW = 4'h4; // converter clock half period, divider bit clear
  localparam logic [3:0] CONV_HALF_FAST = 4'h2; // converter clock half period, divider bit set
  localparam logic [15:0] FILT_CYC_21 = 16'h0180; // converter cycles per 21-bit conversion
  localparam logic [15:0] FILT_CYC_22 = 16'h0300; // converter cycles per 22-bit conversion
  localparam logic [3:0] SETTLE_CYC = 4'h2; // converter cycles after a mux switch
  localparam logic [7:0] RAM_BASE = 8'h00; // engine RAM word of handle 0

  // sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_ACCUM, SEQ_STORE} amf_seq_t;

endpackage

// ==== verilog/amf_sample_path.sv ====
// multiplexed converter sample path: config registers, slot sequencer, decimator, engine RAM writer
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module amf_sample_path (
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // converter side
  input wire logic modulatorBit,
  output logic converterClock,
  output logic [3:0] slotInputSelect,
  output logic conversionStart,
  output logic frameSync,
  // analog and clock controls
  output logic pair01DiffEnable,
  output logic pair45DiffEnable,
  output logic pair67DiffEnable,
  output logic preampGain8Enable,
  output logic remoteLinkBEnable,
  output logic remoteLinkCEnable,
  output logic fastClockSelect,
  output logic converterDivSelect,
  // compute-engine RAM write port
  output logic ceRamWrite,
  output logic [7:0] ceRamAddr,
  output logic [31:0] ceRamData
);

  // ===========================================================
  // configuration storage
  logic [7:0] slotByte_ff [0:5]; // six bytes of slot selects and frame count
  logic [7:0] inputCfg_ff; // filter length and differential enables
  logic [7:0] clockCfg_ff; // clock speed selects
  logic [7:0] preampCfg_ff; // pre-amplifier control
  logic [7:0] remoteCfg_ff; // remote sensor enables
  logic [7:0] regRdData_ff; // read data, one cycle after strobe

  // address decode
  wire [15:0] slotOfs = regAddr - amf_pkg::OFS_SLOT_FIRST;
  wire hitSlot = (regAddr >= amf_pkg::OFS_SLOT_FIRST) && (regAddr <= amf_pkg::OFS_SLOT_LAST);
  wire [2:0] slotIdx = slotOfs[2:0];
  wire hitInput = (regAddr == amf_pkg::OFS_INPUT_CFG);
  wire hitClock = (regAddr == amf_pkg::OFS_CLOCK_CFG);
  wire hitPreamp = (regAddr == amf_pkg::OFS_PREAMP_CFG);
  wire hitRemote = (regAddr == amf_pkg::OFS_REMOTE_CFG);

  // read mux; unmapped addresses return zero
  wire [7:0] rdSel = hitSlot ? slotByte_ff[slotIdx] :
                     hitInput ? inputCfg_ff :
                     hitClock ? clockCfg_ff :
                     hitPreamp ? preampCfg_ff :
                     hitRemote ? remoteCfg_ff : 8'h00;

  // ===========================================================
  // register writes and reads
  // all fields clear on reset, plain read/write storage
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 6; i++)
      begin
        slotByte_ff[i] <= amf_pkg::CFG_RESET;
      end
      inputCfg_ff <= amf_pkg::CFG_RESET;
      clockCfg_ff <= amf_pkg::CFG_RESET;
      preampCfg_ff <= amf_pkg::CFG_RESET;
      remoteCfg_ff <= amf_pkg::CFG_RESET;
    end
    else if (regWr)
    begin
      // one target per address, others untouched
      if (hitSlot)
      begin
        slotByte_ff[slotIdx] <= regWrData;
      end
      if (hitInput)
      begin
        inputCfg_ff <= regWrData;
      end
      if (hitClock)
      begin
        clockCfg_ff <= regWrData;
      end
      if (hitPreamp)
      begin
        preampCfg_ff <= regWrData;
      end
      if (hitRemote)
      begin
        remoteCfg_ff <= regWrData;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      regRdData_ff <= 8'h00;
    end
    else
    begin
      regRdData_ff <= regRd ? rdSel : 8'h00;
    end
  end
  assign regRdData = regRdData_ff;

  // ===========================================================
  // static control outputs straight from the config bytes
  assign pair01DiffEnable = inputCfg_ff[amf_pkg::FLD_DIFF01];
  assign pair45DiffEnable = inputCfg_ff[amf_pkg::FLD_DIFF45];
  assign pair67DiffEnable = inputCfg_ff[amf_pkg::FLD_DIFF67];
  // gain stage exists on pair 0-1 only; clear leaves unity
  assign preampGain8Enable = preampCfg_ff[amf_pkg::FLD_PREAMP];
  assign remoteLinkBEnable = remoteCfg_ff[amf_pkg::FLD_RMT_B];
  assign remoteLinkCEnable = remoteCfg_ff[amf_pkg::FLD_RMT_C];
  assign fastClockSelect = clockCfg_ff[amf_pkg::FLD_FAST_CLK];
  assign converterDivSelect = clockCfg_ff[amf_pkg::FLD_CONV_DIV];

  // decoded filter settings
  wire [1:0] filterLengthCode = inputCfg_ff[amf_pkg::FLD_FILT_LSB +: 2];
  // code 10 is the long filter; 00 and 11 fall back to the short one
  wire longFilter = (filterLengthCode == amf_pkg::FILT_CODE_22);
  wire [15:0] filterCycles = longFilter ? amf_pkg::FILT_CYC_22 : amf_pkg::FILT_CYC_21;

  // frame length, clamped to eleven so a bad value cannot address missing slots
  wire [3:0] frameRaw = slotByte_ff[0][amf_pkg::FLD_FRAME_LSB +: 4];
  wire [3:0] frameSlotCount = (frameRaw > amf_pkg::MAX_SLOTS) ? amf_pkg::MAX_SLOTS : frameRaw;

  // ===========================================================
  // converter clock divider
  logic [3:0] divCnt_ff; // core clocks into this half period
  logic convClk_ff; // converter clock level
  // divider bit picks the half period of both converter and filter clocks
  wire [3:0] halfPeriod = converterDivSelect ? amf_pkg::CONV_HALF_FAST : amf_pkg::CONV_HALF_SLOW;
  wire halfDone = (divCnt_ff >= halfPeriod - 4'h1);
  // one core cycle per converter rising edge; decimator advances only then
  wire convTick = halfDone && !convClk_ff;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      divCnt_ff <= 4'h0;
      convClk_ff <= 1'b0;
    end
    else if (halfDone)
    begin
      divCnt_ff <= 4'h0;
      convClk_ff <= !convClk_ff;
    end
    else
    begin
      divCnt_ff <= divCnt_ff + 4'h1;
    end
  end
  assign converterClock = convClk_ff;

  // ===========================================================
  // modulator bit synchroniser
  logic modSync1_ff; // first stage, read only by the second
  logic modSync2_ff; // second stage
  logic modSync3_ff; // third stage
  logic modBit_ff; // accepted level once stages two and three agree

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      modSync1_ff <= 1'b0;
      modSync2_ff <= 1'b0;
      modSync3_ff <= 1'b0;
      modBit_ff <= 1'b0;
    end
    else
    begin
      modSync1_ff <= modulatorBit;
      modSync2_ff <= modSync1_ff;
      modSync3_ff <= modSync2_ff;
      if (modSync2_ff == modSync3_ff)
      begin
        modBit_ff <= modSync3_ff;
      end
    end
  end

  // ===========================================================
  // slot sequencer and decimator
  amf_pkg::amf_seq_t state_ff;
  amf_pkg::amf_seq_t nxt_state;
  logic [3:0] slot_ff; // current slot in the frame
  logic [15:0] cycCnt_ff; // converter cycles in this phase
  logic signed [21:0] accum_ff; // decimation sum, +1/-1 per cycle
  logic [3:0] handle_ff; // input handle latched at slot start
  logic startPulse_ff; // one-cycle conversion start
  logic syncPulse_ff; // one-cycle frame start
  logic ceWr_ff; // one-cycle RAM write strobe
  logic [7:0] ceAddr_ff; // RAM word address
  logic [31:0] ceData_ff; // RAM word data

  // per-slot select: slot k lives in byte 5-k/2, nibble k%2
  wire [2:0] selByte = 3'h5 - slot_ff[3:1];
  wire [7:0] selSrc = slotByte_ff[selByte];
  wire [3:0] curSelect = slot_ff[0] ? selSrc[7:4] : selSrc[3:0];

  wire frameOn = (frameSlotCount != 4'h0);
  wire lastSlot = (slot_ff >= frameSlotCount - 4'h1);
  wire settleDone = (cycCnt_ff[3:0] >= amf_pkg::SETTLE_CYC - 4'h1);
  wire accumDone = (cycCnt_ff >= filterCycles - 16'h0001);

  // resolution: sign-extend from bit 20 for the short filter
  wire signed [21:0] res21 = {{(amf_pkg::RES_BITS_22 - amf_pkg::RES_BITS_21 + 1){accum_ff[20]}}, accum_ff[19:0]};
  wire signed [21:0] result = longFilter ? accum_ff : res21;
  // left-justify by nine, zeros below, sign fills the top
  wire [31:0] storeWord = {result[21], result, {amf_pkg::RES_SHIFT{1'b0}}};

  // next-state logic
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      amf_pkg::SEQ_IDLE:
      begin
        if (frameOn && convTick)
        begin
          nxt_state = amf_pkg::SEQ_SETTLE;
        end
      end
      amf_pkg::SEQ_SETTLE:
      begin
        if (convTick && settleDone)
        begin
          nxt_state = amf_pkg::SEQ_ACCUM;
        end
      end
      amf_pkg::SEQ_ACCUM:
      begin
        if (convTick && accumDone)
        begin
          nxt_state = amf_pkg::SEQ_STORE;
        end
      end
      amf_pkg::SEQ_STORE:
      begin
        // frame length cleared mid-frame stops after this store
        nxt_state = frameOn ? amf_pkg::SEQ_SETTLE : amf_pkg::SEQ_IDLE;
      end
    endcase
  end

  // state, counters and accumulator
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_ff <= amf_pkg::SEQ_IDLE;
      slot_ff <= 4'h0;
      cycCnt_ff <= 16'h0000;
      accum_ff <= 22'sh0;
      handle_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == amf_pkg::SEQ_IDLE)
      begin
        slot_ff <= 4'h0;
        handle_ff <= curSelect;
      end
      else if (state_ff == amf_pkg::SEQ_STORE)
      begin
        // advance slot; wrap at frame end
        slot_ff <= lastSlot ? 4'h0 : slot_ff + 4'h1;
        cycCnt_ff <= 16'h0000;
      end
      else if (convTick)
      begin
        if (state_ff == amf_pkg::SEQ_SETTLE && settleDone)
        begin
          // conversion begins: latch handle, clear sum
          cycCnt_ff <= 16'h0000;
          accum_ff <= 22'sh0;
          handle_ff <= curSelect;
        end
        else
        begin
          cycCnt_ff <= cycCnt_ff + 16'h0001;
          if (state_ff == amf_pkg::SEQ_ACCUM)
          begin
            // one modulator bit per converter cycle
            accum_ff <= modBit_ff ? accum_ff + 22'sh1 : accum_ff - 22'sh1;
          end
        end
      end
    end
  end

  // pulses and the engine RAM write
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      startPulse_ff <= 1'b0;
      syncPulse_ff <= 1'b0;
      ceWr_ff <= 1'b0;
      ceAddr_ff <= 8'h00;
      ceData_ff <= 32'h0000_0000;
    end
    else
    begin
      // start strobe from the sequencer, never from the converter
      startPulse_ff <= (state_ff == amf_pkg::SEQ_SETTLE) && convTick && settleDone;
      syncPulse_ff <= (state_ff == amf_pkg::SEQ_SETTLE) && convTick && settleDone && (slot_ff == 4'h0);
      // single-word write to the handle's address only
      ceWr_ff <= (state_ff == amf_pkg::SEQ_STORE);
      if (state_ff == amf_pkg::SEQ_STORE)
      begin
        ceAddr_ff <= amf_pkg::RAM_BASE + {4'h0, handle_ff};
        ceData_ff <= storeWord;
      end
    end
  end

  // ===========================================================
  // output drive
  assign slotInputSelect = curSelect;
  assign conversionStart = startPulse_ff;
  assign frameSync = syncPulse_ff;
  assign ceRamWrite = ceWr_ff;
  assign ceRamAddr = ceAddr_ff;
  assign ceRamData = ceData_ff;

endmodule // amf_sample_path
